// file: ucsi_defines.vh
// ucsi_defines.vh: offsets, fields, reset values and timing counts
// assumes: included by the status and interrupt block files
//
// Overview of operation
// - tx-end request flag in request bit 3
// - tx-end request forwarded only while mask 0
// - status bit 5 high while buffer full
// - status bit 2 reports framing error
// - status bit 1 reports parity error
// - status bit 0 reports overrun error
// - trigger ones clear matching error flags
// - rx-error bit 5, rx-end bit 4 requests
// - start trigger one sets enabled on the next clock
`ifndef UCSI_DEFINES_VH
`define UCSI_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define UCSI_OFF_IRQ_REQ     12'h000
`define UCSI_OFF_IRQ_MASK    12'h004
`define UCSI_OFF_STATUS      12'h008
`define UCSI_OFF_ERR_CLR     12'h00c
`define UCSI_OFF_START       12'h010
`define UCSI_OFF_ENABLED     12'h014
`define UCSI_OFF_RX_ENABLE   12'h018
`define UCSI_OFF_DATA        12'h01c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define UCSI_IRQ_TX_END      3
`define UCSI_IRQ_RX_END      4
`define UCSI_IRQ_RX_ERR      5
`define UCSI_ST_OVERRUN      0
`define UCSI_ST_PARITY       1
`define UCSI_ST_FRAMING      2
`define UCSI_ST_BUF_FULL     5
`define UCSI_ST_ACTIVE       6

// ---------------------------------------------------------------
// reset values and used request bits
// ---------------------------------------------------------------
`define UCSI_RST_IRQ_MASK    8'h38
`define UCSI_RST_BYTE        8'h00
`define UCSI_IRQ_USED        8'h38

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define UCSI_START_WAIT_CLK  4

`endif

// file: ucsi_sticky_flag.v
// ucsi_sticky_flag.v: one sticky event flag with write-one clear
// assumes: one clock, set wins over clear in the same cycle
`timescale 1ns/1ps
module ucsi_sticky_flag (
	input  wire clk,
	input  wire rst,
	input  wire set_evt,
	input  wire clr,
	output reg  flag
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (set_evt) begin
			flag <= 1'b1;
		end else if (clr) begin
			flag <= 1'b0;
		end
	end
endmodule

// file: ucsi_status_irq.v
// ucsi_status_irq.v: channel status, error clear and interrupt logic
// assumes: apb master on clk; rx/tx shifters supply one-cycle event
// pulses and the received byte, all synchronous to clk
`timescale 1ns/1ps
`include "ucsi_defines.vh"
module ucsi_status_irq (
	input  wire        clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        rx_done,
	input  wire [7:0]  rx_byte,
	input  wire        rx_framing_err,
	input  wire        rx_parity_err,
	input  wire        tx_done,
	input  wire        tx_busy,
	output wire        receive_enable_bit,
	output wire        channel_enabled_status,
	output wire        tx_end_irq,
	output wire        rx_end_irq,
	output wire        rx_error_irq,
	output wire        irq
);

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire       wr_en;
	wire       rd_en;
	wire       hit;
	reg  [7:0] irq_mask_flags_low;
	reg  [7:0] channel_data_buffer;
	reg        buffer_full_status;
	reg        enabled;
	reg        rx_en;
	reg        next_buffer_full;
	wire       framing_error_flag;
	wire       parity_error_flag;
	wire       overrun_error_flag;
	wire       tx_end_irq_flag;
	wire       rx_end_irq_flag;
	wire       rx_error_irq_flag;
	wire [7:0] irq_request_flags_low;
	wire [7:0] rx_channel_status;
	wire       clr_req;
	wire       clr_err;
	wire       overrun_evt;
	wire       data_read;

	assign pready  = 1'b1;
	assign hit     = (paddr == `UCSI_OFF_IRQ_REQ)
		|| (paddr == `UCSI_OFF_IRQ_MASK)
		|| (paddr == `UCSI_OFF_STATUS)
		|| (paddr == `UCSI_OFF_ERR_CLR)
		|| (paddr == `UCSI_OFF_START)
		|| (paddr == `UCSI_OFF_ENABLED)
		|| (paddr == `UCSI_OFF_RX_ENABLE)
		|| (paddr == `UCSI_OFF_DATA);
	assign pslverr = psel && penable && !hit;
	assign wr_en   = psel && penable && pwrite && hit;
	assign rd_en   = psel && penable && !pwrite && hit;
	assign clr_req = wr_en && (paddr == `UCSI_OFF_IRQ_REQ);
	assign clr_err = wr_en && (paddr == `UCSI_OFF_ERR_CLR);
	assign data_read = rd_en && (paddr == `UCSI_OFF_DATA);

	// ---------------------------------------------------------------
	// receive error flags
	// ---------------------------------------------------------------
	assign overrun_evt = rx_done && buffer_full_status && !data_read;

	ucsi_sticky_flag u_fe (
		.clk     (clk),
		.rst     (rst),
		.set_evt (rx_done && rx_framing_err),
		.clr     (clr_err && pwdata[`UCSI_ST_FRAMING]),
		.flag    (framing_error_flag)
	);
	ucsi_sticky_flag u_pe (
		.clk     (clk),
		.rst     (rst),
		.set_evt (rx_done && rx_parity_err),
		.clr     (clr_err && pwdata[`UCSI_ST_PARITY]),
		.flag    (parity_error_flag)
	);
	ucsi_sticky_flag u_ov (
		.clk     (clk),
		.rst     (rst),
		.set_evt (overrun_evt),
		.clr     (clr_err && pwdata[`UCSI_ST_OVERRUN]),
		.flag    (overrun_error_flag)
	);

	// ---------------------------------------------------------------
	// interrupt request flags, cleared by writing one
	// ---------------------------------------------------------------
	ucsi_sticky_flag u_tx_if (
		.clk     (clk),
		.rst     (rst),
		.set_evt (tx_done && enabled),
		.clr     (clr_req && pwdata[`UCSI_IRQ_TX_END]),
		.flag    (tx_end_irq_flag)
	);
	ucsi_sticky_flag u_rx_if (
		.clk     (clk),
		.rst     (rst),
		.set_evt (rx_done && enabled && rx_en),
		.clr     (clr_req && pwdata[`UCSI_IRQ_RX_END]),
		.flag    (rx_end_irq_flag)
	);
	ucsi_sticky_flag u_re_if (
		.clk     (clk),
		.rst     (rst),
		.set_evt (rx_done && enabled && rx_en
			&& (rx_framing_err || rx_parity_err || overrun_evt)),
		.clr     (clr_req && pwdata[`UCSI_IRQ_RX_ERR]),
		.flag    (rx_error_irq_flag)
	);

	assign irq_request_flags_low = {2'b00, rx_error_irq_flag,
		rx_end_irq_flag, tx_end_irq_flag, 3'b000};
	assign rx_channel_status = {1'b0, tx_busy, buffer_full_status, 2'b00,
		framing_error_flag, parity_error_flag, overrun_error_flag};

	assign tx_end_irq   = tx_end_irq_flag
		&& !irq_mask_flags_low[`UCSI_IRQ_TX_END];
	assign rx_end_irq   = rx_end_irq_flag
		&& !irq_mask_flags_low[`UCSI_IRQ_RX_END];
	assign rx_error_irq = rx_error_irq_flag
		&& !irq_mask_flags_low[`UCSI_IRQ_RX_ERR];
	assign irq = tx_end_irq || rx_end_irq || rx_error_irq;

	// ---------------------------------------------------------------
	// buffer, control registers
	// ---------------------------------------------------------------
	always @* begin
		next_buffer_full = buffer_full_status;
		if (data_read) begin
			next_buffer_full = 1'b0;
		end
		if (rx_done && enabled && rx_en) begin
			next_buffer_full = 1'b1;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_mask_flags_low  <= `UCSI_RST_IRQ_MASK;
			channel_data_buffer <= `UCSI_RST_BYTE;
			buffer_full_status  <= 1'b0;
			enabled             <= 1'b0;
			rx_en               <= 1'b0;
		end else begin
			buffer_full_status <= next_buffer_full;
			if (rx_done && enabled && rx_en) begin
				channel_data_buffer <= rx_byte;
			end
			if (wr_en && paddr == `UCSI_OFF_IRQ_MASK) begin
				irq_mask_flags_low <= pwdata[7:0] & `UCSI_IRQ_USED;
			end
			if (wr_en && paddr == `UCSI_OFF_START && pwdata[0]) begin
				enabled <= 1'b1;
			end else if (wr_en && paddr == `UCSI_OFF_ENABLED
				&& pwdata[0]) begin
				enabled <= 1'b0;
			end
			if (wr_en && paddr == `UCSI_OFF_RX_ENABLE) begin
				rx_en <= pwdata[0];
			end
		end
	end

	assign receive_enable_bit     = rx_en;
	assign channel_enabled_status = enabled;

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always @* begin
		case (paddr)
		`UCSI_OFF_IRQ_REQ:   prdata = {24'h000000, irq_request_flags_low};
		`UCSI_OFF_IRQ_MASK:  prdata = {24'h000000, irq_mask_flags_low};
		`UCSI_OFF_STATUS:    prdata = {24'h000000, rx_channel_status};
		`UCSI_OFF_ENABLED:   prdata = {31'h0, enabled};
		`UCSI_OFF_RX_ENABLE: prdata = {31'h0, rx_en};
		`UCSI_OFF_DATA:      prdata = {24'h000000, channel_data_buffer};
		default:             prdata = 32'h00000000;
		endcase
	end
endmodule

// file: ucsi_properties.sv
// ucsi_properties.sv: assertions on the status and irq block
// assumes: bound to ucsi_status_irq, one clock, offsets from defines
`timescale 1ns/1ps
`include "ucsi_defines.vh"
module ucsi_props (
	input wire        clk,
	input wire        rst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        rx_done,
	input wire        rx_framing_err,
	input wire        tx_done,
	input wire        receive_enable_bit,
	input wire        channel_enabled_status,
	input wire        tx_end_irq,
	input wire        rx_end_irq,
	input wire        rx_error_irq,
	input wire        irq
);
	wire       acc = psel && penable;
	wire       rd = acc && !pwrite;
	wire       st_rd = rd && paddr == `UCSI_OFF_STATUS;
	wire       rq_rd = rd && paddr == `UCSI_OFF_IRQ_REQ;
	wire       mk_rd = rd && paddr == `UCSI_OFF_IRQ_MASK;
	wire       clr = acc && pwrite && paddr == `UCSI_OFF_ERR_CLR;
	wire       go = acc && pwrite && paddr == `UCSI_OFF_START;
	wire       rx_ok = rx_done && channel_enabled_status && receive_enable_bit;
	wire       tx_ok = tx_done && channel_enabled_status;
	wire [2:0] req = {rx_error_irq, rx_end_irq, tx_end_irq};
	wire       fe_ev = rx_done && rx_framing_err;
	wire       mk_wr = acc && pwrite && paddr == `UCSI_OFF_IRQ_MASK;
	localparam [7:0] MK_RST = `UCSI_RST_IRQ_MASK;
	reg  [2:0] mk;
	// mask bits 5:3 as software last wrote them
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mk <= MK_RST[5:3];
		end else if (mk_wr) begin
			mk <= pwdata[5:3];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	irq_or_a: assert property (
		rq_rd |-> irq == |(prdata[5:3] & ~mk))
		else $error("irq does not follow unmasked requests");
	mask_blk_a: assert property (
		mk_rd |-> (prdata[5:3] & req) == 3'b000)
		else $error("masked request reaches its output");
	tx_set_a: assert property (
		$past(tx_ok, 2) && rq_rd |-> prdata[3])
		else $error("tx end flag not set");
	rx_full_a: assert property (
		$past(rx_ok, 2) && st_rd |-> prdata[5])
		else $error("buffer full not set");
	fe_set_a: assert property (
		$past(fe_ev, 2) && st_rd |-> prdata[2])
		else $error("framing flag not set");
	err_clr_a: assert property (
		clr && pwdata[2] && !rx_done ##3 st_rd
		|-> !prdata[2] || $past(rx_done) || $past(rx_done, 2))
		else $error("framing flag not cleared");
	err_hold_a: assert property (
		$past(st_rd, 3) && st_rd
		|-> ($past(prdata, 3) & ~prdata & 32'h00000007) == 32'h00000000)
		else $error("error flag dropped without clear");
	start_en_a: assert property (
		go && pwdata[0] |=> channel_enabled_status)
		else $error("start did not enable channel");
endmodule
bind ucsi_status_irq ucsi_props u_props (.*);

// file: ucsi_remote.sv
// ucsi_remote.sv: remote serial side as seen after the shifters
// assumes: tasks are entered just after a rising clk edge
`timescale 1ns/1ps
module ucsi_remote (
	input  wire       clk,
	output reg        rx_done,
	output reg  [7:0] rx_byte,
	output reg        rx_framing_err,
	output reg        rx_parity_err,
	output reg        tx_done,
	output reg        tx_busy
);
	initial {rx_done, rx_byte, rx_framing_err, rx_parity_err} = 11'h000;
	initial {tx_done, tx_busy} = 2'b00;
	task frame(input [7:0] b, input fe, input pe);
		{rx_done, rx_byte, rx_framing_err, rx_parity_err} <= {1'b1, b, fe, pe};
		@(posedge clk);
		{rx_done, rx_framing_err, rx_parity_err} <= 3'b000;
		rx_byte <= ~b;
	endtask
	task send;
		tx_busy <= 1'b1;
		repeat (3) @(posedge clk);
		{tx_busy, tx_done} <= 2'b01;
		@(posedge clk);
		tx_done <= 1'b0;
	endtask
endmodule

// file: ucsi_tb.sv
// ucsi_tb.sv: self-checking bench for the status and irq block
// assumes: remote model drives the shifter-side event inputs
`timescale 1ns/1ps
`include "ucsi_defines.vh"
module testbench;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, q;
	logic        err;
	wire  [31:0] prdata;
	wire  [7:0]  rx_byte;
	wire         pready, pslverr, rx_done, rx_framing_err, rx_parity_err;
	wire         tx_done, tx_busy, receive_enable_bit, channel_enabled_status;
	wire         tx_end_irq, rx_end_irq, rx_error_irq, irq;
	int          fails = 0, checked = 0, cyc = 0;
	always #5 clk = ~clk;
	ucsi_remote rem (.*);
	ucsi_status_irq DUT (.*);
	task summarize;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			fails++;
			summarize();
		end
	end
	task chk(input string n, input [31:0] e, input [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge clk);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		apb(0, a, 0);
		chk($sformatf("reg %h", a), e, q);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(`UCSI_OFF_IRQ_MASK, 32'h38);
		rd(`UCSI_OFF_IRQ_REQ, 32'h0);
		rd(`UCSI_OFF_STATUS, 32'h0);
		apb(0, 12'h0f0, 0);
		chk("slverr", 1, err);
		$display("test reset done");
		apb(1, `UCSI_OFF_START, 0);
		rd(`UCSI_OFF_ENABLED, 32'h0);
		apb(1, `UCSI_OFF_RX_ENABLE, 1);
		chk("rx_enable", 1, receive_enable_bit);
		repeat (`UCSI_START_WAIT_CLK) @(posedge clk);
		apb(1, `UCSI_OFF_START, 1);
		rd(`UCSI_OFF_ENABLED, 32'h1);
		chk("enabled", 1, channel_enabled_status);
		rem.frame(8'h5a, 0, 0);
		rd(`UCSI_OFF_STATUS, 32'h20);
		rd(`UCSI_OFF_IRQ_REQ, 32'h10);
		rd(`UCSI_OFF_DATA, 32'h5a);
		rd(`UCSI_OFF_STATUS, 32'h0);
		apb(1, `UCSI_OFF_IRQ_MASK, 0);
		chk("irq", 1, irq);
		chk("rx_end_irq", 1, rx_end_irq);
		apb(1, `UCSI_OFF_IRQ_REQ, 32'h10);
		chk("irq", 0, irq);
		fork
			rem.send();
			rd(`UCSI_OFF_STATUS, 32'h40);
		join
		rd(`UCSI_OFF_IRQ_REQ, 32'h08);
		chk("tx_end_irq", 1, tx_end_irq);
		chk("irq", 1, irq);
		apb(1, `UCSI_OFF_IRQ_MASK, 32'h08);
		rd(`UCSI_OFF_IRQ_MASK, 32'h08);
		chk("irq", 0, irq);
		$display("test rx and tx done");
		rem.frame(8'h01, 1, 1);
		rd(`UCSI_OFF_STATUS, 32'h26);
		rem.frame(8'h02, 0, 0);
		rd(`UCSI_OFF_STATUS, 32'h27);
		rd(`UCSI_OFF_STATUS, 32'h27);
		rd(`UCSI_OFF_IRQ_REQ, 32'h38);
		chk("rx_error_irq", 1, rx_error_irq);
		apb(1, `UCSI_OFF_ERR_CLR, 0);
		rd(`UCSI_OFF_STATUS, 32'h27);
		apb(1, `UCSI_OFF_ERR_CLR, 32'h02);
		rd(`UCSI_OFF_STATUS, 32'h25);
		apb(1, `UCSI_OFF_ERR_CLR, 32'h05);
		rd(`UCSI_OFF_STATUS, 32'h20);
		$display("test errors done");
		summarize();
	end
endmodule
